// File: rtl/ppbv_bus_policy.sv
// secondary bus clock and power policy driven by the function power state
`timescale 1ns/100ps
module ppbv_bus_policy (
	input wire logic core_clk, // configuration clock
	input wire logic reset_n, // asynchronous reset, active low
	ppbv_policy_if.policy pol // policy inputs and secondary bus controls
);
	import ppbv_pkg::*;

	ppbv_bus_t busState;
	ppbv_bus_t next_busState;

	// target bus state from the programmed power state
	always_comb begin
		next_busState = PPBV_B0;
		if (pol.busCtlPolicyEnable) begin // RULE_01
			if (pol.d3cold) begin
				next_busState = busState; // RULE_05
			end else begin
				case (pol.powerStateField)
					PPBV_D0: next_busState = PPBV_B0; // RULE_05
					PPBV_D1: next_busState = PPBV_B1; // RULE_05
					PPBV_D2: next_busState = PPBV_B2; // RULE_06
					PPBV_D3HOT: begin
						// select only looked at inside the enabled branch
						next_busState = pol.d3hotClockOrPowerSelect ? PPBV_B2 : PPBV_B3; // RULE_02 RULE_03 RULE_04
					end
					default: next_busState = PPBV_B0;
				endcase
			end
		end
	end

	// bus state register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			busState <= PPBV_B0;
		end else begin
			busState <= next_busState;
		end
	end

	// controls from the state; B1 needs no action of ours
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pol.secClockStop <= 1'b0;
			pol.secPowerOff <= 1'b0;
		end else begin
			pol.secClockStop <= (next_busState == PPBV_B2) || (next_busState == PPBV_B3); // RULE_06 RULE_07
			pol.secPowerOff <= (next_busState == PPBV_B3); // RULE_07
		end
	end

	assign pol.secBusState = busState;
endmodule : ppbv_bus_policy

// File: rtl/ppbv_cap_regs.sv
// bridge power extension, state data and product-data capability register bank
`timescale 1ns/100ps
module ppbv_cap_regs (
	input wire logic core_clk, // configuration clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic cfgRead, // configuration read strobe
	input wire logic cfgWrite, // configuration write strobe
	input wire logic [7:0] cfgAddr, // dword offset from capability pointer
	input wire logic [3:0] cfgByteEn, // byte enables, high active
	input wire logic [31:0] cfgWrData, // configuration write data
	output logic [31:0] cfgRdData, // registered read data
	output logic cfgRdValid, // read data valid pulse
	input wire logic busCtlEnableStrap, // strap for bus control enable
	input wire logic d3hotSelectStrap, // strap for D3HOT_CLOCK_OR_POWER_SELECT choice
	input wire ppbv_pkg::ppbv_pstate_t powerStateField, // current function power state
	input wire logic d3cold, // function supply removed
	input wire logic [7:0] stateDataIn, // selected state-dependent data
	output logic secClockStop, // stop secondary bus clock
	output logic secPowerOff, // remove secondary bus power
	output logic [1:0] dataScaleField, // scale field for the pm status word
	output logic [3:0] dataSelectField, // select field for the pm status word
	output logic storeReq, // start a storage transfer, one cycle
	output logic storeWrite, // transfer direction, 1 write
	output logic [6:0] storeAddr, // storage byte address
	output logic [31:0] storeWrData, // data to store
	input wire logic storeDone, // storage transfer finished
	input wire logic [31:0] storeRdData // data fetched from storage
);
	import ppbv_pkg::*;

	ppbv_policy_if pol ();

	logic busCtlPolicyEnable;
	logic d3hotClockOrPowerSelect;
	logic strapTaken;
	logic [7:0] pmStateData;
	logic [7:0] productDataAddress;
	logic [31:0] productDataWord;
	logic storeBusy;
	logic [7:0] bridgePmSupportExt;
	logic [31:0] next_rdData;
	logic addrWrite;
	logic dataWrite;

	// read-only extension bits come from straps caught after reset release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			busCtlPolicyEnable <= 1'b0;
			d3hotClockOrPowerSelect <= 1'b0;
			strapTaken <= 1'b0;
		end else if (!strapTaken) begin
			busCtlPolicyEnable <= busCtlEnableStrap;
			d3hotClockOrPowerSelect <= d3hotSelectStrap;
			strapTaken <= 1'b1;
		end
	end

	// reserved low bits are constant zero, writes never reach them
	assign bridgePmSupportExt = {busCtlPolicyEnable, d3hotClockOrPowerSelect, 6'h00}; // RULE_15

	// state data byte tracks the selected source; scale and select report none
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pmStateData <= PPBV_STATE_DATA_RESET;
		end else begin
			pmStateData <= stateDataIn; // RULE_08
		end
	end

	// data byte is fed from outside, so no local select table is kept
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dataScaleField <= PPBV_DATA_FIELD_NONE;
			dataSelectField <= 4'h0;
		end else begin
			dataScaleField <= PPBV_DATA_FIELD_NONE; // RULE_14
			dataSelectField <= {2'h0, PPBV_DATA_FIELD_NONE}; // RULE_14
		end
	end

	// write decode: address byte at Ah, data word at Ch
	always_comb begin
		addrWrite = 1'b0;
		dataWrite = 1'b0;
		if (cfgWrite && cfgAddr == PPBV_DW_VPD_HDR) begin
			addrWrite = cfgByteEn[PPBV_OFS_ADDRESS[1:0]] && !storeBusy; // RULE_12
		end else if (cfgWrite && cfgAddr == PPBV_DW_PRODUCT_DATA_WORD) begin
			dataWrite = !storeBusy; // RULE_12
		end
	end

	// address register; flag set on read completion, cleared on write completion
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			productDataAddress <= PPBV_ADDRESS_RESET;
		end else if (addrWrite) begin
			productDataAddress <= {cfgWrData[23], cfgWrData[22:18], 2'h0}; // RULE_11
		end else if (storeBusy && storeDone) begin
			productDataAddress[PPBV_BIT_ADDR_FLAG] <= !storeWrite; // RULE_13
		end
	end

	// transfer tracking; a busy transfer ignores further address and data writes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			storeBusy <= 1'b0;
			storeReq <= 1'b0;
			storeWrite <= 1'b0;
		end else begin
			storeReq <= addrWrite;
			if (addrWrite) begin
				storeBusy <= 1'b1;
				storeWrite <= cfgWrData[23]; // RULE_13
			end else if (storeDone) begin
				storeBusy <= 1'b0;
			end
		end
	end

	assign storeAddr = productDataAddress[6:0];
	assign storeWrData = productDataWord;

	// data word, per byte lane from software or whole from storage
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			productDataWord <= PPBV_DATA_WORD_RESET;
		end else if (dataWrite) begin
			for (int i = 0; i < 4; i++) begin
				if (cfgByteEn[i]) begin
					productDataWord[i*8 +: 8] <= cfgWrData[i*8 +: 8];
				end
			end
		end else if (storeBusy && storeDone && !storeWrite) begin
			productDataWord <= storeRdData;
		end
	end

	// read mux; unmapped dwords return zero
	always_comb begin
		next_rdData = 32'h0000_0000;
		if (cfgAddr == PPBV_DW_PM) begin
			next_rdData = {pmStateData, bridgePmSupportExt, 16'h0000}; // RULE_08
		end else if (cfgAddr == PPBV_DW_VPD_HDR) begin
			next_rdData = {8'h00, productDataAddress, PPBV_NEXT_PTR_VALUE, PPBV_CAP_ID_VALUE}; // RULE_09 RULE_10 RULE_12
		end else if (cfgAddr == PPBV_DW_PRODUCT_DATA_WORD) begin
			next_rdData = productDataWord; // RULE_12
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfgRdData <= 32'h0000_0000;
			cfgRdValid <= 1'b0;
		end else begin
			cfgRdValid <= cfgRead;
			if (cfgRead) begin
				cfgRdData <= next_rdData;
			end
		end
	end

	// policy hookup
	assign pol.busCtlPolicyEnable = busCtlPolicyEnable;
	assign pol.d3hotClockOrPowerSelect = d3hotClockOrPowerSelect;
	assign pol.powerStateField = powerStateField;
	assign pol.d3cold = d3cold;
	assign secClockStop = pol.secClockStop;
	assign secPowerOff = pol.secPowerOff;

	ppbv_bus_policy policy (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.pol(pol.policy)
	);
endmodule : ppbv_cap_regs

// File: rtl/ppbv_pkg.sv
// constants and types for the bridge power extension and product-data capability registers
// Operation
// RULE_01 - With the bus control enable bit set, power states drive the secondary clock and power, otherwise they never do.
// RULE_02 - With the select bit set and the function in D3hot, the secondary clock is stopped, giving bus state B2.
// RULE_03 - With the select bit clear and the function in D3hot, secondary bus power is removed, giving bus state B3.
// RULE_04 - The select bit is ignored unless the bus control enable bit reads one.
// RULE_05 - With bus control enabled, D0, D1 and D3cold cause no secondary clock or power action.
// RULE_06 - With bus control enabled, D2 stops the secondary clock, giving bus state B2.
// RULE_07 - With bus control enabled, D3hot stops the secondary clock and also removes power only when B3 is selected.
// RULE_08 - The read-only state data byte, zero after reset, returns the value chosen by the data select field.
// RULE_09 - The product-data capability identifier byte always reads 03h.
// RULE_10 - The product-data next pointer byte always reads 00h, ending the capability list.
// RULE_11 - The product-data address register is read/write and holds a dword-aligned byte address.
// RULE_12 - Identifier, next pointer, address and data registers decode at capability offsets 8h, 9h, Ah and Ch.
// RULE_13 - The top bit of the product-data address register flags completion of the storage transfer.
// RULE_14 - Data scale and data select read as 00b when the state data byte is not implemented.
// RULE_15 - The six reserved low bits of the bridge extension byte read zero and ignore writes.
package ppbv_pkg;
	// byte offsets relative to the capability pointer
	localparam logic [7:0] PPBV_OFS_BRIDGE_EXT = 8'h06;
	localparam logic [7:0] PPBV_OFS_STATE_DATA = 8'h07;
	localparam logic [7:0] PPBV_OFS_CAP_ID = 8'h08;
	localparam logic [7:0] PPBV_OFS_NEXT_PTR = 8'h09;
	localparam logic [7:0] PPBV_OFS_ADDRESS = 8'h0A;
	localparam logic [7:0] PPBV_OFS_DATA_WORD = 8'h0C;
	// dword offsets seen on the configuration port
	localparam logic [7:0] PPBV_DW_PM = 8'h04;
	localparam logic [7:0] PPBV_DW_VPD_HDR = 8'h08;
	localparam logic [7:0] PPBV_DW_PRODUCT_DATA_WORD = 8'h0C;
	// field positions
	localparam int PPBV_BIT_BUS_CTL_EN = 7;
	localparam int PPBV_BIT_D3_SELECT = 6;
	localparam int PPBV_BIT_ADDR_FLAG = 7;
	// fixed and reset values
	localparam logic [7:0] PPBV_CAP_ID_VALUE = 8'h03;
	localparam logic [7:0] PPBV_NEXT_PTR_VALUE = 8'h00;
	localparam logic [7:0] PPBV_STATE_DATA_RESET = 8'h00;
	localparam logic [7:0] PPBV_ADDRESS_RESET = 8'h00;
	localparam logic [31:0] PPBV_DATA_WORD_RESET = 32'h0000_0000;
	localparam logic [1:0] PPBV_DATA_FIELD_NONE = 2'h0;
	// power state field encodings
	typedef enum logic [1:0] {
		PPBV_D0 = 2'h0,
		PPBV_D1 = 2'h1,
		PPBV_D2 = 2'h2,
		PPBV_D3HOT = 2'h3
	} ppbv_pstate_t;
	// secondary bus states, one-hot
	typedef enum logic [3:0] {
		PPBV_B0 = 4'h1,
		PPBV_B1 = 4'h2,
		PPBV_B2 = 4'h4,
		PPBV_B3 = 4'h8
	} ppbv_bus_t;
endpackage : ppbv_pkg

// File: rtl/ppbv_policy_if.sv
// carrier between the register bank and the secondary bus policy logic
`timescale 1ns/100ps
interface ppbv_policy_if;
	import ppbv_pkg::*;
	logic busCtlPolicyEnable;
	logic d3hotClockOrPowerSelect;
	ppbv_pstate_t powerStateField;
	logic d3cold;
	logic secClockStop;
	logic secPowerOff;
	ppbv_bus_t secBusState;
	modport regs (output busCtlPolicyEnable, output d3hotClockOrPowerSelect, output powerStateField,
		output d3cold, input secClockStop, input secPowerOff, input secBusState);
	modport policy (input busCtlPolicyEnable, input d3hotClockOrPowerSelect, input powerStateField,
		input d3cold, output secClockStop, output secPowerOff, output secBusState);
endinterface : ppbv_policy_if

// File: tb/ppbv_cap_regs_chk.sv
// assertions on the capability register bank ports
`timescale 1ns/100ps
module ppbv_cap_regs_chk
	import ppbv_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic reset_n, // reset
	input wire logic cfgRead, // read strobe
	input wire logic [7:0] cfgAddr, // dword offset
	input wire logic [31:0] cfgRdData, // read data
	input wire logic cfgRdValid, // read valid
	input wire logic busCtlEnableStrap, // enable strap
	input wire logic d3hotSelectStrap, // select strap
	input wire ppbv_pkg::ppbv_pstate_t powerStateField, // power state
	input wire logic d3cold, // supply gone
	input wire logic secClockStop, // clock stop
	input wire logic secPowerOff, // power off
	input wire logic [1:0] dataScaleField, // scale
	input wire logic [3:0] dataSelectField // select
);
	logic [1:0] upCnt;
	logic on;
	// policy follows the straps from the second edge after release; checks wait for the third
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			upCnt <= 2'h0;
		end else if (upCnt != 2'h3) begin
			upCnt <= upCnt + 2'h1;
		end
	end
	assign on = upCnt == 2'h3 && busCtlEnableStrap && !d3cold;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	rd_pulse_a: assert property (cfgRdValid == $past(cfgRead)) else $error("read valid");
	hdr_const_a: assert property (cfgRead && cfgAddr == PPBV_DW_VPD_HDR |=>
		cfgRdData[31:24] == 8'h00 && cfgRdData[17:0] == 18'h00003) else $error("header");
	ext_rsvd_a: assert property (cfgRead && cfgAddr == PPBV_DW_PM |=> cfgRdData[21:0] == 22'h0) else $error("rsvd");
	ext_bits_a: assert property (upCnt == 2'h3 && cfgRead && cfgAddr == PPBV_DW_PM |=>
		cfgRdData[23:22] == {busCtlEnableStrap, d3hotSelectStrap}) else $error("ext bits");
	pol_off_a: assert property (upCnt == 2'h3 && !busCtlEnableStrap |=> !secClockStop && !secPowerOff) else $error("off");
	pol_low_a: assert property (on && powerStateField inside {PPBV_D0, PPBV_D1} |=>
		!secClockStop && !secPowerOff) else $error("d0 d1");
	pol_d2_a: assert property (on && powerStateField == PPBV_D2 |=> secClockStop && !secPowerOff) else $error("d2");
	pol_d3_a: assert property (on && powerStateField == PPBV_D3HOT |=>
		secClockStop && secPowerOff == !d3hotSelectStrap) else $error("d3hot");
	cold_hold_a: assert property (upCnt == 2'h3 && d3cold |=> $stable(secClockStop) && $stable(secPowerOff))
		else $error("d3cold");
	no_data_a: assert property (dataScaleField == 2'h0 && dataSelectField == 4'h0) else $error("fields");
endmodule : ppbv_cap_regs_chk
bind ppbv_cap_regs ppbv_cap_regs_chk u_chk (.core_clk, .reset_n, .cfgRead, .cfgAddr, .cfgRdData, .cfgRdValid,
	.busCtlEnableStrap, .d3hotSelectStrap, .powerStateField, .d3cold, .secClockStop, .secPowerOff,
	.dataScaleField, .dataSelectField);

// File: tb/ppbv_cap_regs_tb.sv
// self-checking bench for the capability register bank
`timescale 1ns/100ps
module ppbv_cap_regs_tb;
	import ppbv_pkg::*;
	logic core_clk = 1'b0, reset_n = 1'b0, cfgRead = 1'b0, cfgWrite = 1'b0, en = 1'b1, sel = 1'b1, d3cold = 1'b0;
	logic [7:0] cfgAddr = 8'h00, stateDataIn = 8'h00;
	logic [3:0] cfgByteEn = 4'h0, lag = 4'h8;
	logic [31:0] cfgWrData = 32'h0, cfgRdData, storeWrData, storeRdData, s = 32'hBB04C2D1;
	logic [31:0] cmpCount = 32'h0, errorCnt = 32'h0, cyc = 32'h0, reqCnt = 32'h0, expQ[$];
	logic cfgRdValid, secClockStop, secPowerOff, storeReq, storeWrite, storeDone;
	logic [1:0] dataScaleField;
	logic [3:0] dataSelectField;
	logic [6:0] storeAddr;
	ppbv_pstate_t ps = PPBV_D0;
	ppbv_cap_regs u_dut (.core_clk, .reset_n, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData,
		.cfgRdValid, .busCtlEnableStrap(en), .d3hotSelectStrap(sel), .powerStateField(ps), .d3cold, .stateDataIn,
		.secClockStop, .secPowerOff, .dataScaleField, .dataSelectField, .storeReq, .storeWrite, .storeAddr,
		.storeWrData, .storeDone, .storeRdData);
	ppbv_store_model u_store (.core_clk, .storeReq, .storeWrite, .storeWrData, .lag, .storeDone, .storeRdData);
	always #5 core_clk = ~core_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrapUp;
		if (errorCnt == 0 && cmpCount != 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrapUp
	// one access per two cycles so no strobe is driven twice in a step
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		if (!w) expQ.push_back(d);
		cfgRead <= !w;
		cfgWrite <= w;
		cfgAddr <= a;
		cfgByteEn <= be;
		cfgWrData <= w ? d : ~d;
		@(posedge core_clk);
		{cfgRead, cfgWrite} <= 2'h0;
		@(posedge core_clk);
	endtask : acc
	// storage request fields stay valid until done, which comes within the model's delay
	task automatic waitDone(input logic [7:0] exp);
		check({24'h0, storeWrite, storeAddr}, {24'h0, exp});
		for (int i = 0; i < 40 && storeDone !== 1'b1; i++) @(posedge core_clk);
		@(posedge core_clk);
	endtask : waitDone
	// read results paired with the oldest expectation
	always @(posedge core_clk) begin
		cyc <= cyc + 32'h1;
		// every accepted address write must start exactly one transfer
		if (storeReq === 1'b1) reqCnt <= reqCnt + 32'h1;
		if (cfgRdValid === 1'b1 && expQ.size() != 0) check(cfgRdData, expQ.pop_front());
		if (cyc == 32'h1388) begin
			errorCnt++;
			wrapUp();
		end
	end
	initial begin
		for (int m = 0; m < 3; m++) begin
			s = lfsr(s);
			reset_n <= 1'b0;
			{en, sel, d3cold, stateDataIn} <= {m != 2, m != 1, 1'b0, s[31:24]};
			ps <= PPBV_D0;
			lag <= {1'b1, s[2:0]};
			repeat (12) @(posedge core_clk);
			reset_n <= 1'b1;
			repeat (3) @(posedge core_clk);
			acc(1'b1, PPBV_DW_PM, 4'hF, 32'hFFFFFFFF);
			acc(1'b0, PPBV_DW_PM, 4'h0, {s[31:24], en, sel, 22'h0});
			for (int p = 0; p < 5; p++) begin
				d3cold <= p == 4;
				ps <= ppbv_pstate_t'(p == 4 ? 0 : p);
				repeat (3) @(posedge core_clk);
				check({secPowerOff, secClockStop}, {en && p > 2 && !sel, en && p > 1});
				check({26'h0, dataScaleField, dataSelectField}, 32'h0);
			end
			acc(1'b0, PPBV_DW_VPD_HDR, 4'h0, 32'h00000003);
			acc(1'b1, PPBV_DW_PRODUCT_DATA_WORD, 4'hF, s);
			// no address lane enabled: must not start a transfer
			acc(1'b1, PPBV_DW_VPD_HDR, 4'hB, {8'h00, 1'b0, ~s[6:2], 2'h3, 16'hFFFF});
			acc(1'b1, PPBV_DW_VPD_HDR, 4'hF, {8'h00, 1'b1, s[6:2], 2'h3, 16'hFFFF});
			acc(1'b1, PPBV_DW_PRODUCT_DATA_WORD, 4'hF, 32'h0);
			check(storeWrData, s);
			waitDone({1'b1, s[6:2], 2'h0});
			acc(1'b0, PPBV_DW_VPD_HDR, 4'h0, {8'h00, 1'b0, s[6:2], 18'h00003});
			acc(1'b1, PPBV_DW_PRODUCT_DATA_WORD, 4'hF, ~s);
			acc(1'b1, PPBV_DW_VPD_HDR, 4'h4, {8'h00, 1'b0, s[6:2], 18'h0});
			// second address write while busy is dropped
			acc(1'b1, PPBV_DW_VPD_HDR, 4'h4, {8'h00, 1'b1, ~s[6:2], 18'h0});
			waitDone({1'b0, s[6:2], 2'h0});
			acc(1'b0, PPBV_DW_VPD_HDR, 4'h0, {8'h00, 1'b1, s[6:2], 18'h00003});
			acc(1'b0, PPBV_DW_PRODUCT_DATA_WORD, 4'h0, s);
			acc(1'b0, 8'h10, 4'h0, 32'h0);
		end
		repeat (4) @(posedge core_clk);
		check(32'(expQ.size()), 32'h0);
		check(reqCnt, 32'h6);
		wrapUp();
	end
endmodule : ppbv_cap_regs_tb

// File: tb/ppbv_store_model.sv
// storage stand-in answering transfer requests after a set delay
`timescale 1ns/100ps
module ppbv_store_model (
	input wire logic core_clk, // clock
	input wire logic storeReq, // transfer start
	input wire logic storeWrite, // 1 write
	input wire logic [31:0] storeWrData, // data in
	input wire logic [3:0] lag, // answer delay
	output logic storeDone, // finished pulse
	output logic [31:0] storeRdData // fetched data
);
	logic [31:0] word = 32'h0;
	logic [4:0] cnt = 5'h0;
	logic rd = 1'b0;
	initial storeDone = 1'b0;
	initial storeRdData = 32'h0;
	// data lines toggle while idle so a stale value never passes for fetched data
	always @(posedge core_clk) begin
		storeDone <= 1'b0;
		storeRdData <= ~storeRdData;
		if (storeReq) begin
			cnt <= {1'b0, lag} + 5'h1;
			rd <= !storeWrite;
			if (storeWrite) word <= storeWrData;
		end else if (cnt != 5'h0) begin
			cnt <= cnt - 5'h1;
			storeDone <= cnt == 5'h1;
			if (cnt == 5'h1 && rd) storeRdData <= word;
		end
	end
endmodule : ppbv_store_model
